// ===== wdt_timer.sv
// Watchdog timer block: configuration registers, strap defaults, arming,
// countdown, timeout flag, watchdog output and interrupt routing.
// Assumes the register strobes come from host-bus logic on ref_clk.
// Contract
// - Enable bit 0 gates timer; strap sets default
// - Base high powers up 0x04 strapped, writable
// - Base low powers up 0x42 strapped, writable
// - Interrupt-select bit 4 enables timeout interrupt
// - Interrupt-select bits 3-0 pick the channel
// - Unit field: 10ms, 1s, 1min, reserved
// - Status-control strap default 0x01, else 0x00; strapped it reads 0x02 here (unit 1s)
// - Status bit 0 shows timeout occurred
// - Writing one clears flag; zero leaves it
// - Count register holds ticks before expiry
// - Same non-zero count twice arms; else stops
// - Count powers up 0x0A strapped, else 0x00
`timescale 1ns/1ps
`default_nettype none
module wdt_timer
  import wdt_pkg::*;
#(
  parameter int BASE_CYCLES = TICK_BASE_CYCLES,
  parameter int CHANNELS = IRQ_CHANNELS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic watchdog_strap_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic wdt_out_n,
  output logic [CHANNELS-1:0] irq_req
);

  if (CHANNELS < 1 || CHANNELS > (1 << IRQ_CHANNEL_W)) begin : g_bad_chan
    $error("wdt_timer: CHANNELS must be 1 to 16");
  end

  typedef enum logic [1:0] {
    PH_SYNC_A = 2'b00,
    PH_SYNC_B = 2'b01,
    PH_LOAD = 2'b10,
    PH_RUN = 2'b11
  } wdt_phase_type;

  typedef struct packed {
    wdt_phase_type phase;
    logic strap_s1;
    logic strap_s2;
    logic timer_on;
    logic [7:0] base_high_byte;
    logic [7:0] base_low_byte;
    logic timeout_irq_enable;
    logic [IRQ_CHANNEL_W-1:0] timeout_irq_channel;
    logic [UNIT_W-1:0] tick_unit_select;
    logic timeout_flag;
    logic [7:0] tick_count;
    logic [7:0] last_wr;
    logic arm_pend;
    logic running;
    logic [7:0] remain;
    logic [7:0] rdata;
    logic wdt_n;
    logic [CHANNELS-1:0] irq;
  } wdt_state_type;

  wdt_state_type s_r;
  wdt_state_type s_nxt;
  logic tick_base;
  logic tick_sec;
  logic tick_min;
  logic tick_sel;
  logic arm_now;
  logic access_ok;
  logic [CHANNELS-1:0] irq_hit;

  wdt_tick_div #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .clear(arm_now),
    .tick_base(tick_base),
    .tick_sec(tick_sec),
    .tick_min(tick_min)
  );

  assign access_ok = (s_r.phase == PH_RUN);

  // Reserved unit code never ticks, so the countdown holds
  always_comb begin
    case (s_r.tick_unit_select)
      UNIT_10MS: tick_sel = tick_base;
      UNIT_1S: tick_sel = tick_sec;
      UNIT_1MIN: tick_sel = tick_min;
      default: tick_sel = 1'b0;
    endcase
  end

  // Second identical non-zero write arms, only while enabled
  assign arm_now = access_ok && reg_wr && (reg_index == IDX_TIMER_COUNT_VALUE) && s_r.arm_pend &&
                   (reg_wdata == s_r.last_wr) && (reg_wdata != 8'h00) && s_r.timer_on;

  // One line per channel, raised only for the selected one
  for (genvar i = 0; i < CHANNELS; i++) begin : g_irq
    assign irq_hit[i] = s_r.timeout_flag && s_r.timeout_irq_enable &&
                        (s_r.timeout_irq_channel == IRQ_CHANNEL_W'(i));
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.strap_s1 = watchdog_strap_pin;
    s_nxt.strap_s2 = s_r.strap_s1;
    s_nxt.wdt_n = !s_r.timeout_flag;
    s_nxt.irq = irq_hit;
    case (s_r.phase)
      PH_SYNC_A: s_nxt.phase = PH_SYNC_B;
      PH_SYNC_B: s_nxt.phase = PH_LOAD;
      PH_LOAD: begin
        // Strap caught after release, never under the async reset
        s_nxt.phase = PH_RUN;
        if (s_r.strap_s2) begin
          s_nxt.timer_on = TIMER_ON_STRAP;
          s_nxt.base_high_byte = BASE_HIGH_STRAP;
          s_nxt.base_low_byte = BASE_LOW_STRAP;
          s_nxt.tick_unit_select = STATUS_CONTROL_STRAP[UNIT_W-1:0];
          s_nxt.tick_count = COUNT_STRAP;
        end
      end
      PH_RUN: begin
        if (reg_rd) begin
          case (reg_index)
            IDX_WATCHDOG_ENABLE: s_nxt.rdata = {7'h0, s_r.timer_on};
            IDX_BASE_ADDRESS_HIGH: s_nxt.rdata = s_r.base_high_byte;
            IDX_BASE_ADDRESS_LOW: s_nxt.rdata = s_r.base_low_byte;
            IDX_INTERRUPT_SELECT: s_nxt.rdata = {3'h0, s_r.timeout_irq_enable, s_r.timeout_irq_channel};
            IDX_TIMER_STATUS_CONTROL: s_nxt.rdata = {5'h0, s_r.tick_unit_select, s_r.timeout_flag};
            IDX_TIMER_COUNT_VALUE: s_nxt.rdata = s_r.tick_count;
            default: s_nxt.rdata = REG_RESET;
          endcase
        end
        if (reg_wr) begin
          case (reg_index)
            IDX_WATCHDOG_ENABLE: s_nxt.timer_on = reg_wdata[TIMER_ON_BIT];
            IDX_BASE_ADDRESS_HIGH: s_nxt.base_high_byte = reg_wdata;
            IDX_BASE_ADDRESS_LOW: s_nxt.base_low_byte = reg_wdata;
            IDX_INTERRUPT_SELECT: begin
              s_nxt.timeout_irq_enable = reg_wdata[IRQ_ENABLE_BIT];
              s_nxt.timeout_irq_channel = reg_wdata[IRQ_CHANNEL_LSB +: IRQ_CHANNEL_W];
            end
            IDX_TIMER_STATUS_CONTROL: begin
              s_nxt.tick_unit_select = reg_wdata[UNIT_LSB +: UNIT_W];
              if (reg_wdata[FLAG_BIT]) begin
                s_nxt.timeout_flag = 1'b0;
              end
            end
            IDX_TIMER_COUNT_VALUE: begin
              s_nxt.tick_count = reg_wdata;
              if (arm_now) begin
                s_nxt.running = 1'b1;
                s_nxt.remain = reg_wdata;
                s_nxt.arm_pend = 1'b0;
              end else begin
                s_nxt.running = 1'b0;
                s_nxt.arm_pend = (reg_wdata != 8'h00);
                s_nxt.last_wr = reg_wdata;
              end
            end
            default: ;
          endcase
        end
        if (!s_nxt.timer_on) begin
          s_nxt.running = 1'b0;
        end else if (s_r.running && !arm_now && tick_sel && s_nxt.running) begin
          if (s_r.remain <= 8'h01) begin
            // Expiry is set after any clear, so a coincident event wins
            s_nxt.remain = 8'h00;
            s_nxt.running = 1'b0;
            s_nxt.timeout_flag = 1'b1;
          end else begin
            s_nxt.remain = s_r.remain - 8'h01;
          end
        end
      end
      default: s_nxt.phase = PH_SYNC_A;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.wdt_n <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign wdt_out_n = s_r.wdt_n;
  assign irq_req = s_r.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence arm_second_write;
    ce && access_ok && reg_wr && (reg_index == IDX_TIMER_COUNT_VALUE) && s_r.timer_on &&
    s_r.arm_pend && (reg_wdata == s_r.last_wr) && (reg_wdata != 8'h00);
  endsequence

  sequence expire_cause;
    ce && access_ok && s_r.timer_on && s_r.running && tick_sel && (s_r.remain == 8'h01) && !reg_wr;
  endsequence

  chk_enable_stops: assert property (
    ce && access_ok && !s_r.timer_on && !reg_wr |=> !s_r.running)
    else $error("timer runs while disabled");

  chk_strap_defaults: assert property (
    ce && (s_r.phase == PH_LOAD) && s_r.strap_s2 |=> (s_r.base_high_byte == BASE_HIGH_STRAP) &&
    (s_r.base_low_byte == BASE_LOW_STRAP) && (s_r.tick_count == COUNT_STRAP) && s_r.timer_on &&
    (s_r.tick_unit_select == UNIT_1S))
    else $error("strap defaults not loaded");

  chk_irq_gated: assert property (
    ce && !s_r.timeout_irq_enable |=> (irq_req == '0))
    else $error("interrupt raised while disabled");

  chk_irq_route: assert property (
    ce && s_r.timeout_flag && s_r.timeout_irq_enable && (int'(s_r.timeout_irq_channel) < CHANNELS) |=>
    irq_req[$past(s_r.timeout_irq_channel)] && $onehot(irq_req))
    else $error("interrupt not on selected channel");

  chk_unit_reserved: assert property (
    ce && (s_r.tick_unit_select == 2'h3) && !reg_wr |=> $stable(s_r.remain) && !s_r.timeout_flag ||
    $past(s_r.timeout_flag))
    else $error("reserved unit still counts");

  chk_flag_clear: assert property (
    ce && access_ok && reg_wr && (reg_index == IDX_TIMER_STATUS_CONTROL) && reg_wdata[FLAG_BIT] &&
    !s_r.running |=> !s_r.timeout_flag)
    else $error("timeout flag not cleared by write of one");

  chk_arm_seq: assert property (
    arm_second_write |=> s_r.running && (s_r.remain == $past(reg_wdata)))
    else $error("double write did not arm");

  chk_bad_write_stops: assert property (
    ce && access_ok && reg_wr && (reg_index == IDX_TIMER_COUNT_VALUE) && !arm_now |=> !s_r.running)
    else $error("mismatched count write left timer running");

  chk_expire: assert property (
    expire_cause |=> s_r.timeout_flag && !s_r.running && (s_r.remain == 8'h00))
    else $error("expiry did not set the flag");

  chk_wdt_out: assert property (
    ce && s_r.timeout_flag |=> !wdt_out_n)
    else $error("watchdog output not asserted");

endmodule
`default_nettype wire

// ===== wdt_pkg.sv
// Constants shared by the watchdog timer block: register indexes, field positions,
// reset and strap values, tick timing.
// Assumes a 100 MHz ref_clk.
package wdt_pkg;

  // Register indexes
  localparam logic [7:0] IDX_WATCHDOG_ENABLE = 8'h30;
  localparam logic [7:0] IDX_BASE_ADDRESS_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_ADDRESS_LOW = 8'h61;
  localparam logic [7:0] IDX_INTERRUPT_SELECT = 8'h70;
  localparam logic [7:0] IDX_TIMER_STATUS_CONTROL = 8'hF0;
  localparam logic [7:0] IDX_TIMER_COUNT_VALUE = 8'hF1;

  // Field positions
  localparam int TIMER_ON_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 4;
  localparam int IRQ_CHANNEL_LSB = 0;
  localparam int IRQ_CHANNEL_W = 4;
  localparam int UNIT_LSB = 1;
  localparam int UNIT_W = 2;
  localparam int FLAG_BIT = 0;

  // Values without strap, and with the strap pin pulled up
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic TIMER_ON_STRAP = 1'b1;
  localparam logic [7:0] BASE_HIGH_STRAP = 8'h04;
  localparam logic [7:0] BASE_LOW_STRAP = 8'h42;
  localparam logic [7:0] STATUS_CONTROL_STRAP = 8'h01;
  localparam logic [7:0] COUNT_STRAP = 8'h0A;

  // Tick unit codes
  localparam logic [1:0] UNIT_10MS = 2'h0;
  localparam logic [1:0] UNIT_1S = 2'h1;
  localparam logic [1:0] UNIT_1MIN = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_BASE_MS = 10;
  localparam int TICK_SECOND_MS = 1000;
  localparam int TICK_MINUTE_S = 60;
  localparam int TICK_BASE_CYCLES = (TICK_BASE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TICKS_PER_SECOND = TICK_SECOND_MS / TICK_BASE_MS;

  localparam int IRQ_CHANNELS = 16;

endpackage

// ===== wdt_tick_div.sv
// Tick divider: one-cycle pulses every 10 ms, 1 s and 1 min of ref_clk.
// Assumes clear and ce come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_div
  import wdt_pkg::*;
#(
  parameter int BASE_CYCLES = TICK_BASE_CYCLES,
  parameter int SECOND_STEPS = TICKS_PER_SECOND,
  parameter int MINUTE_STEPS = TICK_MINUTE_S
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  output logic tick_base,
  output logic tick_sec,
  output logic tick_min
);
  localparam int BW = $clog2(BASE_CYCLES);
  localparam int SW = $clog2(SECOND_STEPS);
  localparam int MW = $clog2(MINUTE_STEPS);

  if (BASE_CYCLES < 2 || SECOND_STEPS < 2 || MINUTE_STEPS < 2) begin : g_bad_div
    $error("wdt_tick_div: every divider stage needs at least 2 steps");
  end

  typedef struct packed {
    logic [BW-1:0] base_cnt;
    logic [SW-1:0] sec_cnt;
    logic [MW-1:0] min_cnt;
    logic t_base;
    logic t_sec;
    logic t_min;
  } wdt_div_state_type;

  wdt_div_state_type s_r;
  wdt_div_state_type s_nxt;

  // Derived from the clock, all three stages cascade
  always_comb begin
    s_nxt = s_r;
    s_nxt.t_base = 1'b0;
    s_nxt.t_sec = 1'b0;
    s_nxt.t_min = 1'b0;
    if (clear) begin
      s_nxt.base_cnt = '0;
      s_nxt.sec_cnt = '0;
      s_nxt.min_cnt = '0;
    end else if (s_r.base_cnt == BW'(BASE_CYCLES - 1)) begin
      s_nxt.base_cnt = '0;
      s_nxt.t_base = 1'b1;
      if (s_r.sec_cnt == SW'(SECOND_STEPS - 1)) begin
        s_nxt.sec_cnt = '0;
        s_nxt.t_sec = 1'b1;
        if (s_r.min_cnt == MW'(MINUTE_STEPS - 1)) begin
          s_nxt.min_cnt = '0;
          s_nxt.t_min = 1'b1;
        end else begin
          s_nxt.min_cnt = s_r.min_cnt + 1'b1;
        end
      end else begin
        s_nxt.sec_cnt = s_r.sec_cnt + 1'b1;
      end
    end else begin
      s_nxt.base_cnt = s_r.base_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign tick_base = s_r.t_base;
  assign tick_sec = s_r.t_sec;
  assign tick_min = s_r.t_min;

  chk_sec_on_base: assert property (@(posedge ref_clk) disable iff (rst)
    tick_sec |-> tick_base)
    else $error("second tick without base tick");

  chk_base_spacing: assert property (@(posedge ref_clk) disable iff (rst)
    tick_base && ce |=> !tick_base)
    else $error("base ticks back to back");

endmodule
`default_nettype wire

// ===== wdt_host_model.sv
// Host model of the configuration register port.
// Assumes the bench calls its tasks at a falling edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module wdt_host_model
  import wdt_pkg::*;
(
  input wire logic ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_index,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_index = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released fields turn inverted, so stale bus values are never trusted
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] data);
    reg_wr = 1'b1;
    reg_index = idx;
    reg_wdata = data;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_index = ~idx;
    reg_wdata = ~data;
    @(negedge ref_clk);
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] data);
    reg_rd = 1'b1;
    reg_index = idx;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_index = ~idx;
    data = reg_rdata;
    @(negedge ref_clk);
  endtask
  // Same non-zero value twice, nothing else to the count register between
  task automatic arm(input logic [7:0] cnt);
    wr_reg(IDX_TIMER_COUNT_VALUE, cnt);
    wr_reg(IDX_TIMER_COUNT_VALUE, cnt);
  endtask
endmodule
`default_nettype wire

// ===== test_watchdog_timer_block.sv
// Self-checking bench for the watchdog timer block.
// Assumes BASE_CYCLES of 4, so a 10 ms tick is 4 clocks.
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timer_block;
  import wdt_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] wdata; logic [7:0] exp;} wdt_row_type;
  logic ref_clk, rst, ce, strap, reg_wr, reg_rd, wdt_out_n;
  logic [7:0] reg_index, reg_wdata, reg_rdata, rdv;
  logic [15:0] irq_req;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  int lo_tbl [4] = '{2, 380, 23900, 1000};
  int hi_tbl [4] = '{10, 420, 24100, 1000};
  // Reserved bits read 0, unmapped index reads 0
  wdt_row_type rows [7] = '{'{8'h30, 8'hFF, 8'h01}, '{8'h60, 8'hA5, 8'hA5}, '{8'h61, 8'h5A, 8'h5A},
    '{8'h70, 8'hFF, 8'h1F}, '{8'hF0, 8'hFE, 8'h06}, '{8'hF1, 8'h7E, 8'h7E}, '{8'h55, 8'hFF, 8'h00}};
  logic [7:0] strap_exp [7] = '{8'h01, 8'h04, 8'h42, 8'h00, 8'h02, 8'h0A, 8'h00};

  wdt_timer #(.BASE_CYCLES(4), .CHANNELS(16)) u_wdt_timer (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .watchdog_strap_pin(strap), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wdt_out_n(wdt_out_n), .irq_req(irq_req));
  wdt_host_model u_wdt_host_model (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    u_wdt_host_model.rd_reg(idx, rdv);
    check({8'h00, rdv}, {8'h00, exp});
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask
  // Bounded wait for the watchdog output to fall
  task automatic wait_out(input int hi, output int cnt);
    cnt = 0;
    while (wdt_out_n !== 1'b0 && cnt < hi) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask
  task automatic quiet(input int cyc);
    repeat (cyc) @(negedge ref_clk);
    check({15'h0000, wdt_out_n}, 16'h0001);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Longest case is one minute unit, about 24k clocks
  initial begin
    #(400us);
    fail_count++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    strap = 1'b0;
    do_reset();
    for (int i = 0; i < 7; i++) rdchk(rows[i].idx, 8'h00);
    for (int i = 0; i < 7; i++) begin
      u_wdt_host_model.wr_reg(rows[i].idx, rows[i].wdata);
      rdchk(rows[i].idx, rows[i].exp);
    end
    // Countdown with interrupt on channel 9
    u_wdt_host_model.wr_reg(IDX_INTERRUPT_SELECT, 8'h19);
    u_wdt_host_model.wr_reg(IDX_TIMER_STATUS_CONTROL, 8'h00);
    u_wdt_host_model.arm(8'h03);
    wait_out(20, n);
    check(16'(n >= 8 && wdt_out_n === 1'b0), 16'h0001);
    @(negedge ref_clk);
    check(irq_req, 16'h0200);
    rdchk(IDX_TIMER_STATUS_CONTROL, 8'h01);
    rdchk(IDX_TIMER_COUNT_VALUE, 8'h03);
    u_wdt_host_model.wr_reg(IDX_TIMER_STATUS_CONTROL, 8'h00);
    rdchk(IDX_TIMER_STATUS_CONTROL, 8'h01);
    u_wdt_host_model.wr_reg(IDX_INTERRUPT_SELECT, 8'h09);
    check({irq_req[14:0], wdt_out_n}, 16'h0000);
    u_wdt_host_model.wr_reg(IDX_TIMER_STATUS_CONTROL, 8'h01);
    check({15'h0000, wdt_out_n}, 16'h0001);
    rdchk(IDX_TIMER_STATUS_CONTROL, 8'h00);
    // Mismatched pair, armed then zeroed, and disabled timer never expire
    u_wdt_host_model.wr_reg(IDX_TIMER_COUNT_VALUE, 8'h03);
    u_wdt_host_model.wr_reg(IDX_TIMER_COUNT_VALUE, 8'h04);
    quiet(60);
    u_wdt_host_model.arm(8'h03);
    u_wdt_host_model.wr_reg(IDX_TIMER_COUNT_VALUE, 8'h00);
    quiet(60);
    u_wdt_host_model.wr_reg(IDX_WATCHDOG_ENABLE, 8'h00);
    u_wdt_host_model.arm(8'h03);
    quiet(60);
    u_wdt_host_model.wr_reg(IDX_WATCHDOG_ENABLE, 8'h01);
    // Every unit code; writing bit 0 also clears the previous timeout
    for (int u = 0; u < 4; u++) begin
      u_wdt_host_model.wr_reg(IDX_TIMER_STATUS_CONTROL, 8'(u << 1) | 8'h01);
      u_wdt_host_model.arm(8'h01);
      wait_out(hi_tbl[u], n);
      check({15'h0000, wdt_out_n}, (u == 3) ? 16'h0001 : 16'h0000);
      check(16'(n >= lo_tbl[u]), 16'h0001);
    end
    // Strapped power-on values; unit field takes the strap value
    strap = 1'b1;
    do_reset();
    for (int i = 0; i < 7; i++) rdchk(rows[i].idx, strap_exp[i]);
    // Clock enable low drops a write
    ce = 1'b0;
    u_wdt_host_model.wr_reg(IDX_BASE_ADDRESS_HIGH, 8'h77);
    ce = 1'b1;
    rdchk(IDX_BASE_ADDRESS_HIGH, 8'h04);
    quiet(20);
    give_verdict();
  end
endmodule
`default_nettype wire
